// *** verilog/nand_host.sv ***
// host controller sequencing two-plane program, copy-back, erase, status
// Functional notes
// - first plane data then dummy confirm ends plane load.
// - after dummy confirm, poll ready bit six with status read.
// - second plane load starts with second-plane input code, address, data.
// - last plane followed by real program confirm; both pages program.
// - same row in both planes, only plane select bit differs.
// - only status reads or reset between dummy confirm and second load.
// - copy-back source and destination stay in one plane.
// - erase setup plus three address cycles, once or twice.
// - erase confirm starts erase; done when ready pin or bit six high.
// - status mode persists; reissue read command before data reads.
// - mask unused status bits when interpreting; the code masks only the reg_dstat readout, not the reg_stat check bits.
//
// Added by the designer: the register offsets and strobed register access.
module nand_host
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // software register port
    input  wire logic [3:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic [31:0]                  rdata,
    // device data feed for writes
    input  wire logic                    wr_byte_valid,
    input  wire logic [7:0]              wr_byte,
    output logic                         wr_byte_ready,
    // device data read back: rd_byte_valid tied low, rd_byte holds the last byte read
    output logic                         rd_byte_valid,
    output logic [7:0]                   rd_byte,
    // device pins
    input  wire logic [7:0]              io_in,
    input  wire logic                    ready_busy_n,
    output logic                         ce_n,
    output logic                         cle,
    output logic                         ale,
    output logic                         we_n,
    output logic                         output_strobe_n,
    output logic [7:0]                   io_out,
    output logic                         io_oe,
    output logic                         wp_n
);

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [11:0] {
        s_idle   = 12'h001,
        s_cmd1   = 12'h002,
        s_addr1  = 12'h004,
        s_data1  = 12'h008,
        s_mid    = 12'h010,
        s_poll   = 12'h020,
        s_cmd2   = 12'h040,
        s_addr2  = 12'h080,
        s_data2  = 12'h100,
        s_conf   = 12'h200,
        s_wait   = 12'h400,
        s_stat   = 12'h800
    } state_type;

    state_type    state_ff;
    state_type    nxt_state;
    logic [3:0]   op_ff;
    logic [31:0]  row_ff;
    logic [15:0]  col_ff;
    logic [12:0]  len_ff;
    logic [12:0]  bcnt_ff;
    logic [2:0]   acnt_ff;
    logic         plane_ff;
    logic         two_ff;
    logic         busy_ff;
    logic [7:0]   dstat_ff;
    logic [7:0]   rdata_b_ff;
    logic [31:0]  rdata_ff;
    logic         wp_ff;
    logic         err_ff;

    // ----------------------------------------------------------------
    // cycle engine
    // ----------------------------------------------------------------
    logic                       cyc_valid;
    nand_host_pkg::cyc_req_type cyc_req;
    logic                       cyc_ready;
    logic                       cyc_done;
    logic [7:0]                 cyc_rd;
    nand_host_pkg::pins_type    pins;

    nand_cycle i_nand_cycle
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .req_valid (cyc_valid),
        .req       (cyc_req),
        .req_ready (cyc_ready),
        .done      (cyc_done),
        .rd_byte   (cyc_rd),
        .io_in     (io_in),
        .pins      (pins)
    );

    assign ce_n            = pins.ce_n;
    assign cle             = pins.cle;
    assign ale             = pins.ale;
    assign we_n            = pins.we_n;
    assign output_strobe_n = pins.output_strobe_n;
    assign io_out          = pins.io_out;
    assign io_oe           = pins.io_oe;
    assign wp_n            = wp_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire is_prog  = (op_ff == nand_host_pkg::op_prog2);
    wire is_copy  = (op_ff == nand_host_pkg::op_copy2);
    wire is_rst   = (op_ff == nand_host_pkg::op_reset);
    wire is_rdc   = (op_ff == nand_host_pkg::op_read);
    wire is_erase = (op_ff == nand_host_pkg::op_erase2);
    wire is_stat  = (op_ff == nand_host_pkg::op_status) ||
                    (op_ff == nand_host_pkg::op_pstatus) ||
                    (op_ff == nand_host_pkg::op_cstatus);
    wire start    = wr_en && addr == nand_host_pkg::reg_ctrl &&
                    state_ff == s_idle;
    wire abort    = wr_en && addr == nand_host_pkg::reg_ctrl &&
                    wdata[3:0] == nand_host_pkg::op_reset;
    wire dev_rdy  = ready_busy_n;
    // erase takes three row cycles, page ops take two column and three row
    wire [2:0] alen = is_erase ? 3'd3 : 3'd5;
    wire last_a   = (acnt_ff == alen - 3'd1);
    wire last_b   = (bcnt_ff == len_ff - 13'd1) || len_ff == 13'd0;
    wire data_ph  = (state_ff == s_data1 || state_ff == s_data2);
    // row with the plane select bit forced; all other row bits equal
    wire [23:0] row_p = {row_ff[23:7], plane_ff, row_ff[5:0]};

    wire [39:0] addr_bytes = {row_p, col_ff};
    wire [7:0]  addr_sel   = is_erase ? row_p[8*acnt_ff[1:0] +: 8]
                                      : addr_bytes[8*acnt_ff +: 8];

    // first command of each plane load
    wire [7:0] first_cmd =
        is_rst   ? nand_host_pkg::cmd_reset :
        is_rdc   ? nand_host_pkg::cmd_read :
        is_erase ? nand_host_pkg::cmd_erase_setup :
        (state_ff == s_cmd2) ? nand_host_pkg::cmd_plane2_in :
        is_copy  ? nand_host_pkg::cmd_copy_in :
                   nand_host_pkg::cmd_data_in;
    wire [7:0] stat_cmd =
        (op_ff == nand_host_pkg::op_pstatus) ?
            nand_host_pkg::cmd_plane_stat :
        (op_ff == nand_host_pkg::op_cstatus) ?
            nand_host_pkg::cmd_check_stat :
            nand_host_pkg::cmd_status;
    wire [7:0] conf_cmd = is_erase ? nand_host_pkg::cmd_erase_go
                                   : nand_host_pkg::cmd_prog_go;

    // ----------------------------------------------------------------
    // cycle request select
    // ----------------------------------------------------------------
    always_comb
    begin
        cyc_valid     = 1'b0;
        cyc_req       = '0;
        wr_byte_ready = 1'b0;
        case (state_ff)
            s_cmd1, s_cmd2:
            begin
                cyc_valid = !busy_ff;
                cyc_req   = '{nand_host_pkg::cyc_cmd, first_cmd};
            end
            s_addr1, s_addr2:
            begin
                cyc_valid = !busy_ff;
                cyc_req   = '{nand_host_pkg::cyc_addr, addr_sel};
            end
            s_data1, s_data2:
            begin
                cyc_valid     = !busy_ff && (is_prog ? wr_byte_valid : 1'b1);
                wr_byte_ready = !busy_ff && is_prog && cyc_ready;
                cyc_req = '{is_prog ? nand_host_pkg::cyc_wr
                                    : nand_host_pkg::cyc_wr, wr_byte};
            end
            s_mid:
            begin
                cyc_valid = !busy_ff;
                cyc_req   = '{nand_host_pkg::cyc_cmd,
                              nand_host_pkg::cmd_prog_dummy};
            end
            s_poll:
            begin
                // only status reads between dummy confirm and second load
                cyc_valid = !busy_ff;
                cyc_req   = (acnt_ff == 3'd0) ?
                    '{nand_host_pkg::cyc_cmd, nand_host_pkg::cmd_status} :
                    '{nand_host_pkg::cyc_rd, 8'h00};
            end
            s_conf:
            begin
                cyc_valid = !busy_ff;
                cyc_req   = '{nand_host_pkg::cyc_cmd, conf_cmd};
            end
            s_stat:
            begin
                cyc_valid = !busy_ff;
                cyc_req   = (acnt_ff == 3'd0) ?
                    '{nand_host_pkg::cyc_cmd, stat_cmd} :
                    '{nand_host_pkg::cyc_rd, 8'h00};
            end
            default:
            begin
                cyc_valid = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            s_idle:
                if (start && wdata[3:0] != nand_host_pkg::op_none)
                    nxt_state = (wdata[3:0] == nand_host_pkg::op_status ||
                                 wdata[3:0] == nand_host_pkg::op_pstatus ||
                                 wdata[3:0] == nand_host_pkg::op_cstatus)
                                ? s_stat : s_cmd1;
            s_cmd1:  if (cyc_done) nxt_state = is_rst ? s_wait :
                         is_rdc ? s_idle : s_addr1;
            s_addr1: if (cyc_done && last_a)
                         nxt_state = is_erase ? (two_ff ? s_cmd2 : s_conf)
                                              : s_data1;
            s_data1: if (cyc_done && last_b)
                         nxt_state = two_ff ? s_mid : s_conf;
            s_mid:   if (cyc_done) nxt_state = s_poll;
            s_poll:  if (cyc_done && acnt_ff != 3'd0 &&
                         cyc_rd[nand_host_pkg::st_ready_bit])
                         nxt_state = s_cmd2;
            s_cmd2:  if (cyc_done) nxt_state = s_addr2;
            s_addr2: if (cyc_done && last_a)
                         nxt_state = is_erase ? s_conf : s_data2;
            s_data2: if (cyc_done && last_b) nxt_state = s_conf;
            s_conf:  if (cyc_done) nxt_state = s_wait;
            s_wait:  if (dev_rdy && !busy_ff) nxt_state = s_stat;
            s_stat:  if (cyc_done && acnt_ff != 3'd0) nxt_state = s_idle;
            default: nxt_state = s_idle;
        endcase
        if (abort)
            nxt_state = s_cmd1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_ff <= s_idle;
            op_ff    <= nand_host_pkg::op_none;
            row_ff   <= '0;
            col_ff   <= '0;
            len_ff   <= '0;
            bcnt_ff  <= '0;
            acnt_ff  <= '0;
            plane_ff <= 1'b0;
            two_ff   <= 1'b0;
            busy_ff  <= 1'b0;
            dstat_ff <= nand_host_pkg::reset_status;
            wp_ff    <= 1'b0;
            err_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            busy_ff  <= cyc_valid && cyc_ready;
            if (wr_en && addr == nand_host_pkg::reg_row)
                row_ff <= wdata;
            if (wr_en && addr == nand_host_pkg::reg_col)
            begin
                col_ff <= wdata[15:0];
                len_ff <= wdata[28:16];
            end
            if (wr_en && addr == nand_host_pkg::reg_ctrl)
            begin
                wp_ff  <= wdata[8];
                two_ff <= wdata[9];
                err_ff <= 1'b0;
                if (start || abort)
                    op_ff <= wdata[3:0];
            end
            if (state_ff != nxt_state)
            begin
                acnt_ff  <= '0;
                bcnt_ff  <= '0;
                plane_ff <= (nxt_state == s_cmd2) ? 1'b1
                          : (nxt_state == s_cmd1) ? 1'b0 : plane_ff;
            end
            else if (cyc_done)
            begin
                acnt_ff <= (state_ff == s_poll || state_ff == s_stat) ?
                           3'd1 : acnt_ff + 3'd1;
                if (data_ph)
                    bcnt_ff <= bcnt_ff + 13'd1;
            end
            // status reading keeps the latest byte; sticky fail flag
            if (cyc_done && (state_ff == s_stat || state_ff == s_poll) &&
                acnt_ff != 3'd0)
            begin
                dstat_ff <= cyc_rd;
                if (cyc_rd[nand_host_pkg::st_fail_bit] && !is_stat)
                    err_ff <= 1'b1;
            end
            else if (abort)
                dstat_ff <= nand_host_pkg::reset_status;
        end
    end

    // ----------------------------------------------------------------
    // software read port
    // ----------------------------------------------------------------
    // masks keep only the bits meaningful for the status kind read
    wire [7:0] smask = (op_ff == nand_host_pkg::op_pstatus) ?
                           nand_host_pkg::plane_mask :
                       (op_ff == nand_host_pkg::op_cstatus) ?
                           nand_host_pkg::check_mask :
                           nand_host_pkg::basic_mask;
    // error-check result trusted only when the valid bit says so
    wire chk_ok  = dstat_ff[nand_host_pkg::st_valid_bit];
    wire chk_err = chk_ok && dstat_ff[nand_host_pkg::st_err_bit];
    wire [31:0] stat_word = {20'h0_0000, chk_ok, chk_err, err_ff,
                             dev_rdy, 3'h0, state_ff == s_idle, 4'h0};
    wire [31:0] rsel =
        (addr == nand_host_pkg::reg_ctrl)  ? {22'h00_0000, two_ff, wp_ff,
                                              4'h0, op_ff} :
        (addr == nand_host_pkg::reg_row)   ? row_ff :
        (addr == nand_host_pkg::reg_col)   ? {3'h0, len_ff, col_ff} :
        (addr == nand_host_pkg::reg_stat)  ? stat_word :
        (addr == nand_host_pkg::reg_rdata) ? {24'h00_0000, rdata_b_ff} :
        (addr == nand_host_pkg::reg_dstat) ? {24'h00_0000,
                                              dstat_ff & smask} :
                                             32'h0000_0000;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rdata_ff   <= '0;
            rdata_b_ff <= '0;
        end
        else
        begin
            rdata_ff <= rd_en ? rsel : 32'h0000_0000;
            if (cyc_done)
                rdata_b_ff <= cyc_rd;
        end
    end

    assign rdata         = rdata_ff;
    assign rd_byte       = rdata_b_ff;
    assign rd_byte_valid = 1'b0;

endmodule : nand_host

// *** verilog/nand_host_pkg.sv ***
// package: commands, status fields, timing and register map of the nand host
package nand_host_pkg;

    // ----------------------------------------------------------------
    // device command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] cmd_data_in     = 8'h80;
    localparam logic [7:0] cmd_plane2_in   = 8'h81;
    localparam logic [7:0] cmd_copy_in     = 8'h85;
    localparam logic [7:0] cmd_prog_go     = 8'h10;
    localparam logic [7:0] cmd_prog_dummy  = 8'h11;
    localparam logic [7:0] cmd_erase_setup = 8'h60;
    localparam logic [7:0] cmd_erase_go    = 8'hd0;
    localparam logic [7:0] cmd_status      = 8'h70;
    localparam logic [7:0] cmd_plane_stat  = 8'hf1;
    localparam logic [7:0] cmd_check_stat  = 8'h7b;
    localparam logic [7:0] cmd_read        = 8'h00;
    localparam logic [7:0] cmd_reset       = 8'hff;

    // ----------------------------------------------------------------
    // status byte fields, page and sector sizes
    // ----------------------------------------------------------------
    localparam int st_fail_bit   = 0;
    localparam int st_plane0_bit = 1;
    localparam int st_plane1_bit = 2;
    localparam int st_err_bit    = 1;
    localparam int st_valid_bit  = 2;
    localparam int st_ready_bit  = 6;
    localparam int st_unprot_bit = 7;
    localparam logic [7:0] basic_mask = 8'hc1;
    localparam logic [7:0] plane_mask = 8'hc7;
    localparam logic [7:0] check_mask = 8'hc7;
    localparam logic [7:0] reset_status = 8'hc0;
    localparam int page_bytes = 4224;
    localparam int sector_bytes = 528;

    // ----------------------------------------------------------------
    // bus timing (clock 50 MHz)
    // ----------------------------------------------------------------
    localparam int clk_mhz = 50;
    localparam int strobe_ns = 40;
    localparam int strobe_cycles = (strobe_ns * clk_mhz + 999) / 1000;
    localparam logic [3:0] strobe_count = 4'(strobe_cycles);

    // ----------------------------------------------------------------
    // host register map (word index)
    // ----------------------------------------------------------------
    localparam logic [3:0] reg_ctrl   = 4'h0;
    localparam logic [3:0] reg_row    = 4'h1;
    localparam logic [3:0] reg_col    = 4'h2;
    localparam logic [3:0] reg_wdata  = 4'h3;
    localparam logic [3:0] reg_stat   = 4'h4;
    localparam logic [3:0] reg_rdata  = 4'h5;
    localparam logic [3:0] reg_dstat  = 4'h6;

    // operation codes written to reg_ctrl[3:0]
    localparam logic [3:0] op_none     = 4'h0;
    localparam logic [3:0] op_prog2    = 4'h1;
    localparam logic [3:0] op_copy2    = 4'h2;
    localparam logic [3:0] op_erase2   = 4'h3;
    localparam logic [3:0] op_status   = 4'h4;
    localparam logic [3:0] op_pstatus  = 4'h5;
    localparam logic [3:0] op_cstatus  = 4'h6;
    localparam logic [3:0] op_reset    = 4'h7;
    localparam logic [3:0] op_read     = 4'h8;

    // one device bus step
    typedef enum logic [1:0] {
        cyc_cmd  = 2'b00,
        cyc_addr = 2'b01,
        cyc_wr   = 2'b10,
        cyc_rd   = 2'b11
    } cyc_kind_type;

    typedef struct packed {
        cyc_kind_type kind;
        logic [7:0]   data;
    } cyc_req_type;

    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       output_strobe_n;
        logic [7:0] io_out;
        logic       io_oe;
    } pins_type;

endpackage : nand_host_pkg

// *** verilog/nand_cycle.sv ***
// single device bus cycle engine: command, address, write or read byte
module nand_cycle
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_b,
    // request
    input  wire logic                       req_valid,
    input  wire nand_host_pkg::cyc_req_type req,
    output logic                            req_ready,
    output logic                            done,
    output logic [7:0]                      rd_byte,
    // device pins
    input  wire logic [7:0]                 io_in,
    output nand_host_pkg::pins_type         pins
);

    typedef enum logic [2:0] {
        idle_type_s = 3'b001,
        low_s       = 3'b010,
        high_s      = 3'b100
    } cstate_type;

    cstate_type                   state_ff;
    cstate_type                   nxt_state;
    logic [3:0]                   cnt_ff;
    nand_host_pkg::cyc_req_type   req_ff;
    logic [7:0]                   rd_ff;
    logic                         done_ff;
    nand_host_pkg::pins_type      pins_ff;
    nand_host_pkg::pins_type      nxt_pins;

    wire cnt_end = (cnt_ff == nand_host_pkg::strobe_count);
    wire nand_host_pkg::cyc_req_type cur = req_ready ? req : req_ff;
    wire is_rd   = (cur.kind == nand_host_pkg::cyc_rd);
    wire active  = (state_ff != idle_type_s);

    assign req_ready = (state_ff == idle_type_s) && !done_ff;
    assign done      = done_ff;
    assign rd_byte   = rd_ff;
    assign pins      = pins_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            idle_type_s: if (req_valid && req_ready) nxt_state = low_s;
            low_s:       if (cnt_end) nxt_state = high_s;
            high_s:      if (cnt_end) nxt_state = idle_type_s;
            default:     nxt_state = idle_type_s;
        endcase
    end

    // strobe low in low_s, latches held through the high phase
    always_comb
    begin
        nxt_pins                 = '0;
        nxt_pins.ce_n            = 1'b0;
        nxt_pins.we_n            = 1'b1;
        nxt_pins.output_strobe_n = 1'b1;
        nxt_pins.cle  = (nxt_state != idle_type_s) &&
                        (cur.kind == nand_host_pkg::cyc_cmd);
        nxt_pins.ale  = (nxt_state != idle_type_s) &&
                        (cur.kind == nand_host_pkg::cyc_addr);
        nxt_pins.io_out = cur.data;
        nxt_pins.io_oe  = (nxt_state != idle_type_s) && !is_rd;
        if (nxt_state == low_s)
        begin
            nxt_pins.we_n            = is_rd;
            nxt_pins.output_strobe_n = !is_rd;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_ff <= idle_type_s;
            cnt_ff   <= '0;
            req_ff   <= '0;
            rd_ff    <= '0;
            done_ff  <= 1'b0;
            pins_ff  <= '{ce_n: 1'b1, we_n: 1'b1, output_strobe_n: 1'b1,
                          default: '0};
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff != nxt_state) ? 4'h0 : cnt_ff + 4'h1;
            if (req_ready && req_valid)
                req_ff <= req;
            // read byte captured at the end of the low phase
            if (state_ff == low_s && cnt_end && is_rd)
                rd_ff <= io_in;
            done_ff <= active && state_ff == high_s && cnt_end;
            pins_ff <= nxt_pins;
        end
    end

endmodule : nand_cycle

// *** tb/nand_host_checker.sv ***
// pin and register port assertions for the nand host
module nand_host_checker
(
    // clock, reset, register port
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    // device pins
    input wire logic        ce_n,
    input wire logic        cle,
    input wire logic        ale,
    input wire logic        we_n,
    input wire logic        output_strobe_n,
    input wire logic [7:0]  io_out,
    input wire logic        io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence wr_pulse; !we_n[*3] ##1 we_n; endsequence
    sequence rd_pulse; !output_strobe_n[*3] ##1 output_strobe_n; endsequence
    a_write_width: assert property ($fell(we_n) |-> wr_pulse)
        else $error("write strobe width wrong");
    a_read_width: assert property ($fell(output_strobe_n) |-> rd_pulse)
        else $error("read strobe width wrong");
    a_read_released: assert property (!output_strobe_n |-> !io_oe)
        else $error("bus driven during read");
    a_latch_exclusive: assert property (!(cle && ale))
        else $error("command and address latch together");
    a_select_held: assert property (!we_n || !output_strobe_n |-> !ce_n)
        else $error("strobe without select");
    a_write_driven: assert property (!we_n |-> io_oe)
        else $error("write strobe with bus released");
    a_byte_steady: assert property (!we_n && !$past(we_n) |-> $stable(io_out))
        else $error("bus byte moved under write strobe");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule : nand_host_checker

// *** tb/nand_dev_model.sv ***
// behavioural flash device: status, busy and command mode
module nand_dev_model
(
    // from host, and plane fail control from the bench
    input  wire logic       clock,
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       we_n,
    input  wire logic       output_strobe_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] io_out,
    input  wire logic [1:0] plane_fail,
    // to host
    output logic [7:0]      io_in,
    output logic            ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_ff = 8'h00;
    logic [7:0] busy_ff = 8'h00;
    logic       fail_ff = 1'b0;
    logic       pw_ff   = 1'b1;
    wire        take = !ce_n && cle && !we_n && pw_ff;
    wire  [7:0] basic = {wp_n, busy_ff == 8'h0, 5'h0, fail_ff};
    wire  [7:0] stat = mode_ff == 8'hf1 ? {basic[7:3], plane_fail, basic[0]}
                     : mode_ff == 8'h7b ? {basic[7:3], 2'b10, basic[0]} : basic;
    assign ready_busy_n = busy_ff == 8'h0;
    always @(posedge clock)
    begin
        pw_ff <= we_n;
        io_in <= (!ce_n && !output_strobe_n) ? stat : ~io_in;
        busy_ff <= busy_ff == 8'h0 ? 8'h0 : busy_ff - 8'h1;
        if (take)
            mode_ff <= io_out;
        if (take && (io_out == 8'h11 || io_out == 8'hff))
            busy_ff <= 8'h04;
        if (take && (io_out == 8'h10 || io_out == 8'hd0))
            busy_ff <= 8'h20;
        if (take && (io_out == 8'h10 || io_out == 8'hd0 || io_out == 8'hff))
            fail_ff <= io_out != 8'hff && |plane_fail;
    end
endmodule : nand_dev_model

// *** tb/nand_host_tb.sv ***
// self-checking bench for the two-plane nand host
module nand_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_b = 0, wr_en = 0, rd_en = 0, pw = 1;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, acc = 0, rdata;
    logic [7:0] io_in, io_out;
    logic [1:0] plane_fail = 0;
    logic ready_busy_n, ce_n, cle, ale, we_n, output_strobe_n, io_oe, wp_n;
    int n_fail = 0, compares = 0;
    nand_host i_nand_host (.clock(clock), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .wr_byte_valid(1'b1), .wr_byte(8'ha5), .wr_byte_ready(),
        .rd_byte_valid(), .rd_byte(), .io_in(io_in), .ready_busy_n(ready_busy_n),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .io_oe(io_oe),
        .output_strobe_n(output_strobe_n), .io_out(io_out), .wp_n(wp_n));
    nand_dev_model i_nand_dev_model (.clock(clock), .ce_n(ce_n), .cle(cle),
        .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n),
        .io_out(io_out), .plane_fail(plane_fail), .io_in(io_in),
        .ready_busy_n(ready_busy_n));
    always #10 clock = ~clock;
    // latched commands bar the 70h and f1h status reads
    always @(posedge clock)
    begin
        pw <= we_n;
        if (!ce_n && cle && !we_n && pw && io_out != 8'h70 && io_out != 8'hf1)
            acc <= {acc[23:0], io_out};
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic run(input logic [31:0] ctrl, output logic [31:0] d);
        acc = 0;
        wr(4'h0, ctrl);
        repeat (4) @(posedge clock);
        for (int i = 0; i < 3000 && d[4] !== 1'b1; i++)
            rd(4'h4, d);
        chk(d[4], 1'b1);
    endtask : run
    task automatic t_flow;
        logic [31:0] d;
        plane_fail = 2'b10;
        wr(4'h2, 32'h0002_0000);
        run(32'h301, d);
        chk(acc, 32'h8011_8110);
        chk(d[9], 1'b1);
        run(32'h302, d);
        chk(acc, 32'h8511_8110);
        plane_fail = 2'b01;
        run(32'h303, d);
        chk(acc, 32'h0060_60d0);
        $display("program and erase test done");
    endtask : t_flow
    task automatic t_status;
        logic [31:0] d;
        logic [7:0] e [3] = '{8'hc1, 8'hc3, 8'hc5};
        for (int k = 0; k < 3; k++)
        begin
            run(32'h104 + k, d);
            rd(4'h6, d);
            chk(d, {24'h0, e[k]});
        end
        run(32'h107, d);
        chk(acc, 32'hff);
        run(32'h104, d);
        rd(4'h6, d);
        chk(d, 32'hc0);
        $display("status and reset test done");
    endtask : t_status
    task automatic results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        t_flow;
        t_status;
        results;
    end
    initial
    begin
        #1_000_000 n_fail++;
        results;
    end
endmodule : nand_host_tb
bind nand_host nand_host_checker i_nand_host_checker (.clock(clock),
    .rst_b(rst_b), .rd_en(rd_en), .rdata(rdata), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .io_out(io_out), .io_oe(io_oe));
